// File: common/blkcopy_defs.vh
// Constants for the table block-copy engine.
// Assumes the host CPU supplies stack levels, accumulator and operand each start.
// Operation
// - Table move takes word count from stack level one.
// - Table move takes source start address from the accumulator.
// - Table move takes destination start from the instruction operand.
// - Table move copies every source word into the same destination position.
// - Label copy takes word count from stack level two.
// - Label copy takes a word offset from stack level one.
// - The one offset is added to both source and destination starts.
// - Label copy source is accumulator: label id or data address.
// - Label copy destination start comes from the instruction operand.
// - Offset counts from zero; no bounds check, overruns copy undefined words.
// - Data-to-label copies are not clipped; overruns overwrite following program.
`ifndef BLKCOPY_DEFS_VH
`define BLKCOPY_DEFS_VH
`define BC_AW 16
`define BC_DW 16
`define BC_FIFO_DEPTH 16
`define BC_FIFO_AW 4
`define BC_OP_MOVE 2'h0
`define BC_OP_DATA_TO_LABEL 2'h1
`define BC_OP_LABEL_TO_DATA 2'h2
`endif

// File: design/blkcopy_fifo.v
// Holds no code: the word FIFO sits beside the copy engine in the engine's own file.
// Assumes nothing of its surroundings.

// File: design/table_block_copy_engine.v
// Block-copy engine: table move and label-area copy between memories.
// Assumes single-cycle-accept memory ports with valid/ready and registered read data.
`include "blkcopy_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module table_block_copy_engine (
    input wire clk_i,
    input wire resetn_i,
    input wire start_i,
    input wire [1:0] op_i,
    input wire [`BC_AW-1:0] stack1_i,
    input wire [`BC_AW-1:0] stack2_i,
    input wire [`BC_AW-1:0] accum_i,
    input wire [`BC_AW-1:0] operand_i,
    output wire busy_o,
    output reg done_o,
    output wire rd_req_o,
    output reg rd_prog_o,
    output reg [`BC_AW-1:0] rd_addr_o,
    input wire rd_gnt_i,
    input wire rd_valid_i,
    input wire [`BC_DW-1:0] rd_data_i,
    output wire wr_req_o,
    output reg wr_prog_o,
    output reg [`BC_AW-1:0] wr_addr_o,
    output wire [`BC_DW-1:0] wr_data_o,
    input wire wr_gnt_i
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RUN = 2'h1;
    localparam [1:0] ST_DONE = 2'h2;
    localparam [`BC_AW-1:0] ONE_W = {{(`BC_AW-1){1'b0}}, 1'b1};

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [`BC_AW-1:0] rd_left_q;
    reg [`BC_AW-1:0] rd_left_d;
    reg [`BC_AW-1:0] wr_left_q;
    reg [`BC_AW-1:0] wr_left_d;
    reg [`BC_AW-1:0] rd_addr_d;
    reg [`BC_AW-1:0] wr_addr_d;
    reg rd_prog_d;
    reg wr_prog_d;
    reg [4:0] inflight_q;
    reg [4:0] inflight_d;
    reg [4:0] occ_q;
    reg [4:0] occ_d;
    reg done_d;
    wire fifo_in_ready;
    wire fifo_out_valid;

    wire [`BC_AW-1:0] len = (op_i == `BC_OP_MOVE) ? stack1_i : stack2_i;
    wire [`BC_AW-1:0] offs = (op_i == `BC_OP_MOVE) ? {`BC_AW{1'b0}} : stack1_i;
    wire running = (state_q == ST_RUN);
    // Reads only issue while FIFO has room for all outstanding words
    wire room = ({1'b0, inflight_q} + 6'h01) <= (6'h10 - {1'b0, occ_q});
    wire rd_fire;
    wire wr_fire;

    assign busy_o = running;
    assign rd_req_o = running && (rd_left_q != {`BC_AW{1'b0}}) && fifo_in_ready && room;
    assign wr_req_o = running && fifo_out_valid;
    assign rd_fire = rd_req_o && rd_gnt_i;
    assign wr_fire = wr_req_o && wr_gnt_i;

    blkcopy_fifo #(
        .W(`BC_DW),
        .DEPTH(`BC_FIFO_DEPTH),
        .AW(`BC_FIFO_AW)
    ) blkcopy_fifo_inst (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .flush_i(start_i && !running),
        .in_valid_i(rd_valid_i && running),
        .in_ready_o(fifo_in_ready),
        .in_data_i(rd_data_i),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(wr_gnt_i && running),
        .out_data_o(wr_data_o)
    );

    // Next-state and datapath decode
    always @* begin
        state_d = state_q;
        rd_left_d = rd_left_q;
        wr_left_d = wr_left_q;
        rd_addr_d = rd_addr_o;
        wr_addr_d = wr_addr_o;
        rd_prog_d = rd_prog_o;
        wr_prog_d = wr_prog_o;
        inflight_d = inflight_q;
        occ_d = occ_q;
        done_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                inflight_d = 5'h00;
                occ_d = 5'h00;
                if (start_i) begin
                    rd_left_d = len;
                    wr_left_d = len;
                    rd_addr_d = accum_i + offs;
                    wr_addr_d = operand_i + offs;
                    rd_prog_d = (op_i == `BC_OP_LABEL_TO_DATA);
                    wr_prog_d = (op_i == `BC_OP_DATA_TO_LABEL);
                    // Zero count skips straight to the done pulse
                    if (len == {`BC_AW{1'b0}}) begin
                        state_d = ST_DONE;
                    end else begin
                        state_d = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (rd_fire) begin
                    rd_left_d = rd_left_q - ONE_W;
                    rd_addr_d = rd_addr_o + ONE_W;
                end
                inflight_d = inflight_q + {4'h0, rd_fire} - {4'h0, rd_valid_i};
                occ_d = occ_q + {4'h0, rd_valid_i} - {4'h0, wr_fire};
                if (wr_fire) begin
                    // No clipping at the label-area end
                    wr_left_d = wr_left_q - ONE_W;
                    wr_addr_d = wr_addr_o + ONE_W;
                    if (wr_left_q == ONE_W) begin
                        state_d = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                done_d = 1'b1;
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            rd_left_q <= {`BC_AW{1'b0}};
            wr_left_q <= {`BC_AW{1'b0}};
            rd_addr_o <= {`BC_AW{1'b0}};
            wr_addr_o <= {`BC_AW{1'b0}};
            rd_prog_o <= 1'b0;
            wr_prog_o <= 1'b0;
            inflight_q <= 5'h00;
            occ_q <= 5'h00;
            done_o <= 1'b0;
        end else begin
            state_q <= state_d;
            rd_left_q <= rd_left_d;
            wr_left_q <= wr_left_d;
            rd_addr_o <= rd_addr_d;
            wr_addr_o <= wr_addr_d;
            rd_prog_o <= rd_prog_d;
            wr_prog_o <= wr_prog_d;
            inflight_q <= inflight_d;
            occ_q <= occ_d;
            done_o <= done_d;
        end
    end

endmodule // table_block_copy_engine

// Word FIFO with valid/ready on both sides; flush empties it in one cycle
module blkcopy_fifo #(
    parameter W = 32,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_i,
    input wire resetn_i,
    input wire flush_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    assign in_ready_o = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_q];

    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_q] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (flush_i) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
            end
            // Simultaneous push and pop leave the count alone
            if (push && !pop) begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // blkcopy_fifo
`default_nettype wire

// File: verif/tbce_checker_asserts.sv
// Port checker for the block-copy engine.
// Assumes a bind onto the engine top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module tbce_checker (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic rd_req_o,
    input wire logic rd_prog_o,
    input wire logic rd_gnt_i,
    input wire logic wr_req_o,
    input wire logic wr_prog_o,
    input wire logic wr_gnt_i,
    input wire logic [15:0] rd_addr_o,
    input wire logic [15:0] wr_addr_o,
    input wire logic [15:0] wr_data_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_rd_take; rd_req_o && rd_gnt_i; endsequence
    sequence s_wr_take; wr_req_o && wr_gnt_i; endsequence
    chk_done_pulse: assert property (done_o |=> !done_o) else $error("done too long");
    chk_busy_end: assert property ($fell(busy_o) |=> done_o) else $error("no done");
    chk_start_answer: assert property (start_i && !busy_o && !done_o && !$past(busy_o) |-> ##[1:2] (busy_o || done_o))
        else $error("start not answered");
    chk_idle_quiet: assert property (!busy_o |-> !rd_req_o && !wr_req_o) else $error("idle request");
    chk_rd_hold: assert property (rd_req_o && !rd_gnt_i |=> rd_req_o && $stable(rd_addr_o))
        else $error("read dropped");
    chk_rd_step: assert property (s_rd_take ##1 rd_req_o |-> rd_addr_o == $past(rd_addr_o) + 16'h0001)
        else $error("read step");
    chk_wr_hold: assert property (wr_req_o && !wr_gnt_i |=> wr_req_o && $stable(wr_data_o))
        else $error("write dropped");
    chk_wr_step: assert property (s_wr_take ##1 wr_req_o |-> wr_addr_o == $past(wr_addr_o) + 16'h0001)
        else $error("write step");
    chk_prog_pair: assert property (busy_o |-> !(rd_prog_o && wr_prog_o)) else $error("prog to prog");
endmodule // tbce_checker
`default_nettype wire

// File: verif/copy_mem_model.sv
// Data and program memory answering the engine's ports.
// Assumes slow_i throttles grants; reads return one cycle after grant.
`timescale 1ns/1ps
`default_nettype none
module copy_mem_model (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic rd_req_i,
    input wire logic rd_prog_i,
    input wire logic wr_req_i,
    input wire logic wr_prog_i,
    input wire logic [15:0] rd_addr_i,
    input wire logic [15:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    output logic rd_gnt_o,
    output logic wr_gnt_o,
    output logic rd_valid_o,
    output logic [15:0] rd_data_o
);
    logic [15:0] dm [0:255];
    logic [15:0] pm [0:255];
    logic [1:0] t_q = 2'h0;
    assign rd_gnt_o = rd_req_i && (!slow_i || t_q[0]);
    assign wr_gnt_o = wr_req_i && (!slow_i || t_q[1]);
    initial begin
        rd_valid_o = 1'b0;
        rd_data_o = 16'h0000;
    end
    always @(posedge clk_i) begin
        t_q <= t_q + 2'h1;
        rd_valid_o <= rd_gnt_o;
        // Idle data line toggles so no stale word looks valid
        rd_data_o <= rd_gnt_o ? (rd_prog_i ? pm[rd_addr_i[7:0]] : dm[rd_addr_i[7:0]]) : ~rd_data_o;
        if (wr_gnt_o && wr_prog_i) pm[wr_addr_i[7:0]] <= wr_data_i;
        if (wr_gnt_o && !wr_prog_i) dm[wr_addr_i[7:0]] <= wr_data_i;
    end
endmodule // copy_mem_model
`default_nettype wire

// File: verif/table_block_copy_engine_tb.sv
// Self-checking bench for the block-copy engine.
// Assumes copy_mem_model as both memories.
`include "blkcopy_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module table_block_copy_engine_tb;
    logic clk_i, resetn_i, start_i, slow, busy_o, done_o, rd_req_o, rd_prog_o, rd_gnt_i, rd_valid_i;
    logic wr_req_o, wr_prog_o, wr_gnt_i;
    logic [1:0] op_i;
    logic [15:0] stack1_i, stack2_i, accum_i, operand_i, rd_addr_o, rd_data_i, wr_addr_o, wr_data_o, k;
    integer error_cnt = 0, n_tests = 0;
    table_block_copy_engine table_block_copy_engine_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .start_i(start_i), .op_i(op_i), .stack1_i(stack1_i), .stack2_i(stack2_i), .accum_i(accum_i),
        .operand_i(operand_i), .busy_o(busy_o), .done_o(done_o), .rd_req_o(rd_req_o), .rd_prog_o(rd_prog_o),
        .rd_addr_o(rd_addr_o), .rd_gnt_i(rd_gnt_i), .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i),
        .wr_req_o(wr_req_o), .wr_prog_o(wr_prog_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
        .wr_gnt_i(wr_gnt_i));
    copy_mem_model copy_mem_model_inst (.clk_i(clk_i), .slow_i(slow), .rd_req_i(rd_req_o),
        .rd_prog_i(rd_prog_o), .wr_req_i(wr_req_o), .wr_prog_i(wr_prog_o), .rd_addr_i(rd_addr_o),
        .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o), .rd_gnt_o(rd_gnt_i), .wr_gnt_o(wr_gnt_i),
        .rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i));
    task chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task go(input logic [1:0] op, input logic [15:0] s1, s2, a, d);
        integer n;
        @(posedge clk_i);
        #1 {op_i, stack1_i, stack2_i, accum_i, operand_i, start_i} = {op, s1, s2, a, d, 1'b1};
        @(posedge clk_i);
        #1 start_i = 1'b0;
        chk({15'h0000, busy_o}, {15'h0000, (op == `BC_OP_MOVE ? s1 : s2) != 16'h0000});
        for (n = 0; n < 500 && done_o !== 1'b1; n++) @(posedge clk_i) #1;
        chk({15'h0000, done_o}, 16'h0001);
    endtask
    task t_move;
        slow = 1'b1;
        go(`BC_OP_MOVE, 16'h0006, 16'h0009, 16'h0010, 16'h0030);
        for (k = 0; k < 7; k++) chk(copy_mem_model_inst.dm[8'h30 + k[7:0]], k < 6 ? 16'ha010 + k : 16'ha036);
        slow = 1'b0;
        $display("test move done");
    endtask
    task t_d2l;
        go(`BC_OP_DATA_TO_LABEL, 16'h0002, 16'h0004, 16'h0020, 16'h0040);
        for (k = 0; k < 6; k++) chk(copy_mem_model_inst.pm[8'h41 + k[7:0]],
            (k == 0 || k == 5) ? 16'h5041 + k : 16'ha021 + k);
        $display("test data to label done");
    endtask
    task t_l2d;
        go(`BC_OP_LABEL_TO_DATA, 16'h0001, 16'h0004, 16'h0008, 16'h0060);
        for (k = 0; k < 4; k++) chk(copy_mem_model_inst.dm[8'h61 + k[7:0]], 16'h5009 + k);
        go(`BC_OP_MOVE, 16'h0000, 16'h0000, 16'h0010, 16'h0070);
        chk(copy_mem_model_inst.dm[8'h70], 16'ha070);
        $display("test label to data and zero count done");
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        {resetn_i, start_i, slow, op_i, stack1_i, stack2_i, accum_i, operand_i} = '0;
        for (k = 0; k < 256; k++) {copy_mem_model_inst.dm[k], copy_mem_model_inst.pm[k]} = {16'ha000 + k, 16'h5000 + k};
        repeat (2) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        t_move;
        t_d2l;
        t_l2d;
        results;
    end
    initial begin
        #20000 error_cnt++;
        results;
    end
endmodule // table_block_copy_engine_tb
bind table_block_copy_engine tbce_checker tbce_checker_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .start_i(start_i), .busy_o(busy_o), .done_o(done_o), .rd_req_o(rd_req_o), .rd_prog_o(rd_prog_o),
    .rd_gnt_i(rd_gnt_i), .wr_req_o(wr_req_o), .wr_prog_o(wr_prog_o), .wr_gnt_i(wr_gnt_i),
    .rd_addr_o(rd_addr_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));
`default_nettype wire
